// *** design/tglc_pkg.sv ***
// Purpose: constants and types for trigger gating and laser control
// Assumes: 25 MHz system clock
// Notes:   distances in mm, encoder scale in pulses per mm (8 fraction bits)
package tglc_pkg;
	localparam int          TGLC_CW        = 24;
	localparam int          TGLC_DW        = 16;
	localparam int          TGLC_FRAC      = 8;
	localparam int          TGLC_CLK_HZ    = 25_000_000;
	localparam int          TGLC_TICK_MS   = 1;
	// one time tick per millisecond in time-controlled mode
	localparam int          TGLC_TICK_CYC  = TGLC_CLK_HZ / 1000 * TGLC_TICK_MS;
	localparam logic [15:0] TGLC_GAP_MM    = 16'h001E;
	localparam logic [15:0] TGLC_SUPP_MM   = 16'h00C8;
	localparam logic [1:0]  TGLC_CAN_INC   = 2'h1;
	localparam logic [1:0]  TGLC_CAN_TRIG  = 2'h2;
	localparam logic [1:0]  TGLC_CAN_OBJ   = 2'h3;

	typedef enum logic [2:0] {
		TGLC_IDLE  = 3'h1,
		TGLC_DELAY = 3'h2,
		TGLC_MEAS  = 3'h4
	} tglc_state_t;

	typedef struct packed {
		logic        free_run;
		logic        sw_trig_src;
		logic        time_mode;
		logic        const_speed;
		logic        laser_ctrl;
		logic        laser_own_src;
		logic [15:0] ppmm_q8;
		logic [15:0] path_delay;
		logic [15:0] expand;
		logic [15:0] sensor_mm;
		logic [15:0] gap_mm;
		logic [15:0] supp_mm;
		logic [15:0] off_delay_ms;
		logic [15:0] const_per;
		logic [15:0] inc_div;
		logic [15:0] out_div;
	} tglc_cfg_t;

	typedef struct packed {
		logic [1:0]  kind;
		logic [23:0] data;
	} tglc_can_t;

	typedef struct packed {
		logic        trig_m, trig_s, trig_p;
		logic        las_m, las_s, las_p;
		logic        enc_m, enc_s, enc_p;
		logic        obj_p;
		logic        sw_lvl;
		logic [15:0] ms_cnt;
		logic [15:0] cp_cnt;
		tglc_state_t st;
		logic [23:0] iv_cnt;
		logic        end_run;
		logic [23:0] end_cnt;
		logic        laser_on;
		logic        acc_run;
		logic [23:0] acc;
		logic        tmo_run;
		logic [15:0] tmo;
		logic [15:0] div_cnt;
		logic [23:0] inc_cnt;
		logic [15:0] out_cnt;
		logic [23:0] pos_start;
		logic        can_vld;
		tglc_can_t   can;
	} tglc_st_t;
endpackage

// *** design/tglc_core.sv ***
// Purpose: measurement gating, laser on/off control and system increment
// Assumes: trigger and encoder pins asynchronous; config static while running
// Notes:   one CAN frame slot; events arriving while it is full are dropped
`timescale 1ns/1ps
`default_nettype none
module tglc_core #(
	parameter int TICK_CYC = tglc_pkg::TGLC_TICK_CYC
) (
	input  wire logic                clk_sys_i,
	input  wire logic                resetn_i,
	input  wire tglc_pkg::tglc_cfg_t cfg_i,
	input  wire logic                trig_pin_i,
	input  wire logic                laser_trig_pin_i,
	input  wire logic                sw_start_i,
	input  wire logic                sw_stop_i,
	input  wire logic                enc_pin_i,
	input  wire logic                obj_present_i,
	input  wire logic                can_ready_i,
	output logic                     meas_active_o,
	output logic                     laser_on_o,
	output logic [23:0]              sys_inc_o,
	output logic                     can_valid_o,
	output tglc_pkg::tglc_can_t      can_frame_o
);
	import tglc_pkg::*;

	tglc_st_t q;
	tglc_st_t d;

	// fixed-point scale; time mode uses the raw figure as milliseconds
	function automatic logic [23:0] to_cnt(input logic [15:0] v, input logic [15:0] s,
			input logic tm);
		logic [31:0] p;
		p = 32'(v) * 32'(s);
		to_cnt = tm ? 24'(v) : p[TGLC_FRAC +: TGLC_CW];
	endfunction

	logic        trig_lvl;
	logic        trig_rise;
	logic        trig_fall;
	logic        las_rise;
	logic        las_fall;
	logic        obj_rise;
	logic        obj_fall;
	logic        ms_tick;
	logic        cp_tick;
	logic        spd_tick;
	logic        adv;
	logic [23:0] dly_cnt;
	logic [23:0] exp_cnt;
	logic [23:0] start_cnt;
	logic [23:0] stop_cnt;
	logic [23:0] off_cnt;
	logic [15:0] off_mm;
	logic        iv_on;
	logic        start_evt;
	logic        end_evt;
	logic        inc_tick;
	logic        msg_tick;
	logic        can_free;

	always_comb begin
		trig_lvl  = cfg_i.sw_trig_src ? q.sw_lvl : q.trig_s;
		trig_rise = trig_lvl & ~q.trig_p;
		trig_fall = ~trig_lvl & q.trig_p;
		las_rise  = q.las_s & ~q.las_p;
		las_fall  = ~q.las_s & q.las_p;
		obj_rise  = obj_present_i & ~q.obj_p;
		obj_fall  = ~obj_present_i & q.obj_p;
		ms_tick   = q.ms_cnt == 16'(TICK_CYC - 1);
		cp_tick   = q.cp_cnt >= cfg_i.const_per;
		// constant speed synthesises pulses so path logic is shared
		spd_tick  = cfg_i.const_speed ? cp_tick : (q.enc_s & ~q.enc_p);
		adv       = cfg_i.time_mode ? ms_tick : spd_tick;
		dly_cnt   = to_cnt(cfg_i.path_delay, cfg_i.ppmm_q8, cfg_i.time_mode);
		exp_cnt   = to_cnt(cfg_i.expand, cfg_i.ppmm_q8, cfg_i.time_mode);
		// start earlier and stop later by the expansion
		start_cnt = (dly_cnt > exp_cnt) ? dly_cnt - exp_cnt : '0;
		stop_cnt  = dly_cnt + exp_cnt;
		off_mm    = cfg_i.sensor_mm + cfg_i.gap_mm + cfg_i.supp_mm;
		off_cnt   = to_cnt(off_mm, cfg_i.ppmm_q8, 1'b0);
		iv_on     = 1'b0;
		start_evt = 1'b0;
		end_evt   = 1'b0;
		inc_tick  = 1'b0;
		msg_tick  = 1'b0;
		can_free  = ~q.can_vld | can_ready_i;

		d = q;
		d.trig_m = trig_pin_i;
		d.trig_s = q.trig_m;
		d.trig_p = trig_lvl;
		d.las_m  = laser_trig_pin_i;
		d.las_s  = q.las_m;
		d.las_p  = q.las_s;
		d.enc_m  = enc_pin_i;
		d.enc_s  = q.enc_m;
		d.enc_p  = q.enc_s;
		d.obj_p  = obj_present_i;
		if (sw_start_i) begin
			d.sw_lvl = 1'b1;
		end else if (sw_stop_i) begin
			d.sw_lvl = 1'b0;
		end
		d.ms_cnt = ms_tick ? '0 : q.ms_cnt + 16'h0001;
		d.cp_cnt = (cp_tick | ~cfg_i.const_speed) ? '0 : q.cp_cnt + 16'h0001;

		// stop counter runs from the trigger's falling edge
		if (trig_fall && q.st != TGLC_IDLE) begin
			d.end_run = 1'b1;
			d.end_cnt = '0;
		end else if (q.end_run && adv) begin
			d.end_cnt = q.end_cnt + 24'h00_0001;
		end

		case (q.st)
			TGLC_IDLE: begin
				d.end_run = 1'b0;
				if (cfg_i.free_run) begin
					if (obj_rise) begin
						d.st      = TGLC_MEAS;
						start_evt = 1'b1;
					end
				end else if (trig_rise) begin
					d.iv_cnt = '0;
					if (start_cnt == '0) begin
						d.st      = TGLC_MEAS;
						start_evt = 1'b1;
					end else begin
						d.st = TGLC_DELAY;
					end
				end
			end
			TGLC_DELAY: begin
				if (adv) begin
					d.iv_cnt = q.iv_cnt + 24'h00_0001;
				end
				if (adv && q.iv_cnt + 24'h00_0001 >= start_cnt) begin
					d.st      = TGLC_MEAS;
					start_evt = 1'b1;
				end
			end
			TGLC_MEAS: begin
				// further triggers and objects do not split the interval
				if (cfg_i.free_run) begin
					end_evt = obj_fall;
				end else begin
					end_evt = q.end_run && q.end_cnt >= stop_cnt;
				end
				if (end_evt) begin
					d.st      = TGLC_IDLE;
					d.end_run = 1'b0;
				end
			end
			default: begin
				d.st = TGLC_IDLE;
			end
		endcase
		iv_on = q.st != TGLC_IDLE;

		// own-source path accumulator
		if (las_rise) begin
			d.acc_run = 1'b0;
			d.acc     = '0;
		end else if (las_fall) begin
			d.acc_run = 1'b1;
			d.acc     = '0;
		end else if (q.acc_run && spd_tick) begin
			d.acc = q.acc + 24'h00_0001;
		end
		if (las_rise) begin
			d.tmo_run = cfg_i.off_delay_ms != '0;
			d.tmo     = '0;
		end else if (q.tmo_run && ms_tick) begin
			d.tmo = q.tmo + 16'h0001;
		end

		if (cfg_i.free_run || !cfg_i.laser_ctrl) begin
			d.laser_on = 1'b1;
		end else if (!cfg_i.laser_own_src) begin
			d.laser_on = iv_on | (d.st != TGLC_IDLE);
		end else if (las_rise) begin
			d.laser_on = 1'b1;
		end else if (q.acc_run && spd_tick && q.acc + 24'h00_0001 >= off_cnt) begin
			d.laser_on = 1'b0;
			d.acc_run  = 1'b0;
		end else if (q.tmo_run && ms_tick && q.tmo + 16'h0001 >= cfg_i.off_delay_ms) begin
			d.laser_on = 1'b0;
			d.tmo_run  = 1'b0;
		end

		// system increment and message interval
		if (spd_tick) begin
			if (q.div_cnt + 16'h0001 >= cfg_i.inc_div) begin
				inc_tick  = 1'b1;
				d.div_cnt = '0;
				d.inc_cnt = q.inc_cnt + 24'h00_0001;
			end else begin
				d.div_cnt = q.div_cnt + 16'h0001;
			end
		end
		if (inc_tick) begin
			if (q.out_cnt + 16'h0001 >= cfg_i.out_div) begin
				msg_tick  = 1'b1;
				d.out_cnt = '0;
			end else begin
				d.out_cnt = q.out_cnt + 16'h0001;
			end
		end

		// one frame slot: object end beats trigger beats increment
		if (can_free) begin
			d.can_vld = 1'b0;
			if (end_evt) begin
				d.can_vld   = 1'b1;
				d.can.kind  = TGLC_CAN_OBJ;
				d.can.data  = q.inc_cnt - q.pos_start;
			end else if (start_evt) begin
				d.can_vld   = 1'b1;
				d.can.kind  = TGLC_CAN_TRIG;
				d.can.data  = q.inc_cnt;
			end else if (msg_tick) begin
				d.can_vld   = 1'b1;
				d.can.kind  = TGLC_CAN_INC;
				d.can.data  = d.inc_cnt;
			end
		end
		if (start_evt) begin
			d.pos_start = q.inc_cnt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q    <= '0;
			q.st <= TGLC_IDLE;
		end else begin
			q <= d;
		end
	end

	assign meas_active_o = q.st == TGLC_MEAS;
	assign laser_on_o    = q.laser_on;
	assign sys_inc_o     = q.inc_cnt;
	assign can_valid_o   = q.can_vld;
	assign can_frame_o   = q.can;

	property p_free_start;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_i.free_run && q.st == TGLC_IDLE && obj_rise |=> meas_active_o;
	endproperty
	a_free_start: assert property (p_free_start) else $error("free-run start missed");

	property p_one_interval;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!cfg_i.free_run && q.st == TGLC_MEAS && trig_rise && !end_evt |=> meas_active_o;
	endproperty
	a_one_interval: assert property (p_one_interval) else $error("interval split");

	property p_delay;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!cfg_i.free_run && q.st == TGLC_IDLE && trig_rise && start_cnt != '0
			|=> q.st == TGLC_DELAY;
	endproperty
	a_delay: assert property (p_delay) else $error("path delay skipped");

	property p_no_ctrl;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!cfg_i.laser_ctrl ##1 !cfg_i.laser_ctrl |-> laser_on_o;
	endproperty
	a_no_ctrl: assert property (p_no_ctrl) else $error("laser off without control");

	property p_free_laser;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_i.free_run |=> laser_on_o;
	endproperty
	a_free_laser: assert property (p_free_laser) else $error("laser off in free run");

	property p_retrig;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_i.laser_ctrl && cfg_i.laser_own_src && !cfg_i.free_run && las_rise
			|=> laser_on_o && q.acc == '0 && !q.acc_run;
	endproperty
	a_retrig: assert property (p_retrig) else $error("retrigger not restarted");

	property p_path_off;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_i.laser_ctrl && cfg_i.laser_own_src && !cfg_i.free_run && !las_rise
			&& q.acc_run && spd_tick && q.acc + 24'h00_0001 >= off_cnt |=> !laser_on_o;
	endproperty
	a_path_off: assert property (p_path_off) else $error("laser stays on past distance");

	property p_inc;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		spd_tick && q.div_cnt + 16'h0001 >= cfg_i.inc_div
			|=> sys_inc_o == $past(sys_inc_o) + 24'h00_0001;
	endproperty
	a_inc: assert property (p_inc) else $error("system increment not advanced");

	// a held frame must not change under the consumer
	property p_can_hold;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		can_valid_o && !can_ready_i |=> can_valid_o && $stable(can_frame_o);
	endproperty
	a_can_hold: assert property (p_can_hold) else $error("frame lost before taken");

	property p_tmo_off;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_i.laser_ctrl && cfg_i.laser_own_src && !cfg_i.free_run && !las_rise
			&& q.tmo_run && ms_tick && q.tmo + 16'h0001 >= cfg_i.off_delay_ms |=> !laser_on_o;
	endproperty
	a_tmo_off: assert property (p_tmo_off) else $error("laser stays on past delay");

	property p_iv_laser;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_i.laser_ctrl && !cfg_i.laser_own_src && !cfg_i.free_run && q.st != TGLC_IDLE
			|=> laser_on_o;
	endproperty
	a_iv_laser: assert property (p_iv_laser) else $error("laser off inside interval");
endmodule
`default_nettype wire

// *** verification/tglc_far_model.sv ***
// Purpose: trigger sensors and conveyor encoder on the far side of the core
// Assumes: pins change just after a falling clock edge
// Notes:   gaps between encoder pulses vary, so speed changes and stops occur
`timescale 1ns/1ps
`default_nettype none
module tglc_far_model (
	input  wire logic clk_sys_i,
	output logic      trig_pin_o,
	output logic      laser_trig_pin_o,
	output logic      enc_pin_o
);
	int n_sent;
	initial begin
		n_sent           = 0;
		trig_pin_o       = 1'b0;
		laser_trig_pin_o = 1'b0;
		enc_pin_o        = 1'b0;
	end
	// pulse width of three cycles clears the two-stage synchroniser
	task automatic pulses(input int n, input int g);
		repeat (n) begin
			enc_pin_o = ~enc_pin_o;
			n_sent++;
			repeat (3) @(negedge clk_sys_i);
			enc_pin_o = ~enc_pin_o;
			repeat (3 + g) @(negedge clk_sys_i);
		end
	endtask
	task automatic trg(input logic lvl);
		trig_pin_o = lvl;
		repeat (5) @(negedge clk_sys_i);
	endtask
	task automatic lsr(input logic lvl);
		laser_trig_pin_o = lvl;
		repeat (5) @(negedge clk_sys_i);
	endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: self-checking bench for the trigger gating and laser core
// Assumes: one pulse per encoder step; ms tick shortened to TICK cycles
// Notes:   waits allow for the synchroniser and the ms tick phase
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tglc_pkg::*;
	localparam int TICK = 10;
	logic        clk_sys_i, resetn_i, sw_start_i, sw_stop_i, obj_present_i, can_ready_i;
	logic        trig_pin, laser_pin, enc_pin, meas, laser, can_valid;
	logic [23:0] sys_inc, inc0;
	logic [23:0] last_data [4];
	tglc_can_t   can_frame;
	tglc_cfg_t   cfg;
	int          mismatches, n_checks, k, n_kind [4];
	logic [31:0] rng;
	tglc_core #(.TICK_CYC(TICK)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cfg_i(cfg),
		.trig_pin_i(trig_pin), .laser_trig_pin_i(laser_pin), .sw_start_i(sw_start_i),
		.sw_stop_i(sw_stop_i), .enc_pin_i(enc_pin), .obj_present_i(obj_present_i),
		.can_ready_i(can_ready_i), .meas_active_o(meas), .laser_on_o(laser),
		.sys_inc_o(sys_inc), .can_valid_o(can_valid), .can_frame_o(can_frame));
	tglc_far_model P (.clk_sys_i(clk_sys_i), .trig_pin_o(trig_pin),
		.laser_trig_pin_o(laser_pin), .enc_pin_o(enc_pin));
	function automatic int gap();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return int'(rng % 6);
	endfunction
	function automatic tglc_cfg_t base();
		tglc_cfg_t c;
		c = '0;
		c.laser_ctrl    = 1'b1;
		c.laser_own_src = 1'b1;
		c.ppmm_q8       = 16'h0200;
		c.path_delay    = 16'h0014;
		c.expand        = 16'h0005;
		c.sensor_mm     = 16'h000A;
		c.gap_mm        = TGLC_GAP_MM;
		c.supp_mm       = TGLC_SUPP_MM;
		c.const_per     = 16'h0008;
		c.inc_div       = 16'h0004;
		c.out_div       = 16'h0002;
		return c;
	endfunction
	// distance to pulses, unsigned, fraction dropped
	function automatic int mm2p(input int mm);
		return (mm * int'(cfg.ppmm_q8)) >> 8;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// both strobes together: start must win
	task automatic tele(input logic st, input logic sp);
		sw_start_i = st;
		sw_stop_i  = sp;
		cyc(1);
		sw_start_i = 1'b0;
		sw_stop_i  = 1'b0;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys_i)
		if (can_valid && can_ready_i) begin
			n_kind[can_frame.kind]++;
			last_data[can_frame.kind] = can_frame.data;
		end
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#2_000_000;
		mismatches++;
		final_report();
	end
	initial begin
		rng = 32'h0000_0015;
		{resetn_i, sw_start_i, sw_stop_i, obj_present_i} = 4'h0;
		can_ready_i = 1'b1;
		cfg = base();
		cyc(16);
		resetn_i = 1'b1;
		cyc(4);
		chk(laser, 0);
		inc0 = sys_inc;
		P.pulses(16, gap());
		cyc(4);
		chk(sys_inc - inc0, 4);
		chk(n_kind[1], 2);
		chk(last_data[1], P.n_sent / 4);
		P.lsr(1);
		chk(laser, 1);
		P.lsr(0);
		P.pulses(200, gap());
		P.lsr(1);
		P.lsr(0);
		k = mm2p(10 + 30 + 200);
		P.pulses(k - 10, gap());
		cyc(4);
		chk(laser, 1);
		P.pulses(12, gap());
		cyc(4);
		chk(laser, 0);
		cfg.off_delay_ms = 16'h0002;
		P.lsr(1);
		chk(laser, 1);
		cyc(2 * TICK + 8);
		chk(laser, 0);
		P.lsr(0);
		cfg = base();
		cfg.laser_ctrl = 1'b0;
		cyc(3);
		chk(laser, 1);
		cfg = base();
		cfg.free_run = 1'b1;
		cyc(3);
		chk(laser, 1);
		obj_present_i = 1'b1;
		cyc(2);
		chk(meas, 1);
		chk(last_data[2], P.n_sent / 4);
		P.pulses(8, gap());
		k = n_kind[3];
		obj_present_i = 1'b0;
		cyc(2);
		chk(meas, 0);
		chk(n_kind[3], k + 1);
		chk(last_data[3], 8 / int'(cfg.inc_div));
		cfg = base();
		cfg.laser_own_src = 1'b0;
		k = n_kind[2];
		P.trg(1);
		chk(laser, 1);
		P.pulses(mm2p(15) - 6, gap());
		chk(meas, 0);
		P.pulses(8, gap());
		cyc(3);
		chk(meas, 1);
		repeat (20) begin
			obj_present_i = gap() > 2;
			cyc(1);
			chk(meas, 1);
		end
		chk(n_kind[2], k + 1);
		P.trg(0);
		P.pulses(mm2p(25) - 10, gap());
		cyc(3);
		chk(meas, 1);
		P.pulses(12, gap());
		cyc(3);
		chk(meas, 0);
		chk(laser, 0);
		cfg.sw_trig_src = 1'b1;
		cfg.time_mode   = 1'b1;
		cfg.path_delay  = 16'h0003;
		cfg.expand      = 16'h0000;
		tele(1'b1, 1'b1);
		cyc(15);
		chk(meas, 0);
		cyc(25);
		chk(meas, 1);
		tele(1'b0, 1'b1);
		cyc(15);
		chk(meas, 1);
		cyc(30);
		chk(meas, 0);
		cfg = base();
		cfg.const_speed = 1'b1;
		inc0 = sys_inc;
		// consumer stalls at random while increments keep coming
		repeat (320) begin
			can_ready_i = gap() > 2;
			cyc(1);
		end
		can_ready_i = 1'b1;
		chk(sys_inc - inc0, (P.n_sent % 4 + 320 / (int'(cfg.const_per) + 1)) / 4);
		cfg.laser_ctrl = 1'b0;
		resetn_i = 1'b0;
		cyc(2);
		chk({meas, can_valid, sys_inc}, 0);
		resetn_i = 1'b1;
		cyc(2);
		chk(laser, 1);
		final_report();
	end
endmodule
`default_nettype wire
